/* File: include/assc_pkg.sv */
// Shared constants and types of the asynchronous serial status and control block
package assc_pkg;

   // Register indices; the byte address of each register is four times its index
   localparam logic [6:0] IDX_STATUS = 7'h50; // Line status flags
   localparam logic [6:0] IDX_DATA = 7'h51; // Data port: transmit holding / receive holding
   localparam logic [6:0] IDX_CTRL1 = 7'h53; // Frame control one
   localparam logic [6:0] IDX_CTRL2 = 7'h54; // Frame control two
   localparam logic [6:0] IDX_DIV = 7'h55; // Sample tick divider

   // Address bits that select the register index
   localparam int unsigned ADR_LO = 2;
   localparam int unsigned ADR_HI = 8;

   // Line status bit positions
   localparam int unsigned B_TRANSMIT_EMPTY_FLAG = 7; // transmit_empty_flag
   localparam int unsigned B_TC = 6; // tx_complete_flag
   localparam int unsigned B_RX_FULL_FLAG = 5; // rx_full_flag
   localparam int unsigned B_IDLE = 4; // idle_line_flag
   localparam int unsigned B_OR = 3; // overrun_flag
   localparam int unsigned B_NF = 2; // noise_flag
   localparam int unsigned B_FE = 1; // framing_error_flag
   localparam int unsigned B_PE = 0; // parity_error_flag

   // Frame control one bit positions
   localparam int unsigned C1_RX9 = 7; // rx_ninth_bit
   localparam int unsigned C1_TX9 = 6; // tx_ninth_bit
   localparam int unsigned C1_LPD = 5; // low_power_disable
   localparam int unsigned C1_M = 4; // word_length_select
   localparam int unsigned C1_WAKE = 3; // wakeup_method
   localparam int unsigned C1_PCE = 2; // parity_enable
   localparam int unsigned C1_PS = 1; // parity_odd_select
   localparam int unsigned C1_PIE = 0; // parity_irq_en

   // Frame control two bit positions
   localparam int unsigned C2_TIE = 7; // tx_empty_irq_en
   localparam int unsigned C2_TX_DONE_IRQ_EN = 6; // tx_done_irq_en
   localparam int unsigned C2_RIE = 5; // rx_irq_en
   localparam int unsigned C2_IDLE_IRQ_EN = 4; // idle_irq_en
   localparam int unsigned C2_TE = 3; // tx_enable
   localparam int unsigned C2_RE = 2; // rx_enable
   localparam int unsigned C2_MUTE = 1; // mute_request
   localparam int unsigned C2_SBK = 0; // break_send

   // Flags cleared by a data write or a data read after a status access
   localparam logic [7:0] CLR_WR_MASK = 8'hC1;
   localparam logic [7:0] CLR_RD_MASK = 8'h3F;

   // Reset values
   localparam logic [7:0] STATUS_RST = 8'hC0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] DIV_RST = 8'h0F;

   // Sixteen samples per bit; the 8th, 9th and 10th are voted
   localparam logic [3:0] SMP_FIRST_VOTE = 4'h7;
   localparam logic [3:0] SMP_LAST_VOTE = 4'h9;
   localparam logic [3:0] SMP_LAST = 4'hF;

   // Data bits per word and idle frame lengths in samples
   localparam logic [3:0] NBITS_8 = 4'h8;
   localparam logic [3:0] NBITS_9 = 4'h9;
   localparam logic [7:0] IDLE_SMP_8 = 8'hA0;
   localparam logic [7:0] IDLE_SMP_9 = 8'hB0;

   // Transmitter states
   typedef enum logic [4:0]
   {
      TX_IDLE = 5'h01,
      TX_WAIT = 5'h02,
      TX_DATA = 5'h04,
      TX_PRE = 5'h08,
      TX_BRK = 5'h10
   } assc_tx_state_t;

   // Receiver states
   typedef enum logic [2:0]
   {
      RX_OFF = 3'h1,
      RX_HUNT = 3'h2,
      RX_BITS = 3'h4
   } assc_rx_state_t;

   // Wishbone request from the master
   typedef struct packed
   {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [31:0] adr;
      logic [31:0] dat;
   } assc_wb_req_t;

   // Wishbone answer to the master
   typedef struct packed
   {
      logic ack;
      logic [31:0] dat;
   } assc_wb_rsp_t;

endpackage

/* File: design/assc_top.sv */
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module assc_top
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Register bus
   input assc_pkg::assc_wb_req_t i_wb,
   output assc_pkg::assc_wb_rsp_t o_wb,
   // Serial line
   input wire logic i_rxd,
   output logic o_txd,
   // Interrupt
   output logic o_irq
);
   import assc_pkg::*;

   // Whole state of the block, registered in one place
   typedef struct packed
   {
      assc_wb_rsp_t rsp; // Bus answer
      logic [7:0] status; // Line status flags
      logic [7:0] ctrl1; // Frame control one
      logic [7:0] ctrl2; // Frame control two
      logic [7:0] div; // Sample tick divider
      logic [7:0] div_cnt; // Divider count
      logic [7:0] seen; // Flags seen at last status access
      logic armed; // Status access waiting for a data access
      logic [7:0] txh; // Transmit holding word
      assc_tx_state_t txs; // Transmitter state
      logic [10:0] tsh; // Transmit shift register
      logic [3:0] tbits; // Bits left in the frame
      logic [3:0] tsmp; // Sample count within a bit
      logic te_prev; // Previous tx_enable
      logic sbk_prev; // Previous break_send
      logic pre_pend; // Preamble queued
      logic brk_pend; // Break word queued
      logic txd; // Line output
      assc_rx_state_t rxs; // Receiver state
      logic [3:0] rsmp; // Sample count within a bit
      logic [3:0] rbits; // Bits taken so far
      logic [8:0] rsh; // Receive shift register
      logic [2:0] votes; // Samples eight to ten
      logic rnoise; // Noise seen in this frame
      logic line_prev; // Previous line sample
      logic [7:0] rxh; // Receive holding word
      logic [7:0] idle_cnt; // High samples while hunting
      logic idle_arm; // Idle flag may be set
      logic rm; // Word length of the frame in progress
      logic rpce; // Parity enable of the frame in progress
      logic rps; // Parity sense of the frame in progress
      logic irq; // Interrupt output
   } assc_state_t;

   assc_state_t st_q; // Current state
   assc_state_t st_d; // Next state
   logic tick; // Sample tick, one cycle
   logic run; // Divider allowed to count
   logic req; // New bus request
   logic [6:0] idx; // Register index
   logic wr; // Byte write
   logic [7:0] clr; // Flags cleared this cycle
   logic [7:0] c2w; // Control two value to write
   logic [8:0] tw; // Transmit word with parity
   logic [3:0] nb; // Transmit data bits
   logic rbit; // Voted bit value
   logic noisy; // Voted samples disagree
   logic [8:0] dat9; // Received word, right aligned
   logic msb; // Received word MSB
   logic perr; // Parity check failed
   logic deliver; // Received word reaches software
   logic [7:0] idle_lim; // Idle frame length in samples

   // Next state of the whole block
   always_comb
   begin
      st_d = st_q;
      st_d.rsp.ack = 1'b0;
      tick = 1'b0;
      clr = 8'h00;
      c2w = 8'h00;
      tw = 9'h000;
      nb = NBITS_8;
      rbit = 1'b0;
      noisy = 1'b0;
      dat9 = 9'h000;
      msb = 1'b0;
      perr = 1'b0;
      deliver = 1'b0;
      idle_lim = st_q.ctrl1[C1_M] ? IDLE_SMP_9 : IDLE_SMP_8;

      // Sample tick divider, frozen in low power once both engines rest
      run = !(st_q.ctrl1[C1_LPD] && st_q.txs == TX_IDLE && st_q.rxs != RX_BITS);
      if (run)
      begin
         if (st_q.div_cnt >= st_q.div)
         begin
            st_d.div_cnt = 8'h00;
            tick = 1'b1;
         end
         else
         begin
            st_d.div_cnt = st_q.div_cnt + 8'h01;
         end
      end

      // Bus slave: one answer per request, the cycle after it is seen
      req = i_wb.cyc && i_wb.stb && !st_q.rsp.ack;
      idx = i_wb.adr[ADR_HI:ADR_LO];
      wr = req && i_wb.we && i_wb.sel[0];
      if (req)
      begin
         st_d.rsp.ack = 1'b1;
         st_d.rsp.dat = 32'h0000_0000;
         if (idx == IDX_STATUS)
         begin
            // Any status access arms the clear and remembers the flags
            st_d.rsp.dat[7:0] = st_q.status;
            st_d.seen = st_q.status;
            st_d.armed = 1'b1;
         end
         else if (idx == IDX_DATA)
         begin
            if (!i_wb.we)
            begin
               st_d.rsp.dat[7:0] = st_q.rxh;
            end
            else if (wr)
            begin
               st_d.txh = i_wb.dat[7:0];
            end
            // Armed data access clears only the flags seen earlier
            if (st_q.armed)
            begin
               clr = (i_wb.we ? CLR_WR_MASK : CLR_RD_MASK) & st_q.seen;
               st_d.armed = 1'b0;
            end
         end
         else if (idx == IDX_CTRL1)
         begin
            st_d.rsp.dat[7:0] = st_q.ctrl1;
            if (wr)
            begin
               st_d.ctrl1[6:0] = i_wb.dat[6:0];
            end
         end
         else if (idx == IDX_CTRL2)
         begin
            st_d.rsp.dat[7:0] = st_q.ctrl2;
            if (wr)
            begin
               c2w = i_wb.dat[7:0];
               // Mute is locked while a word waits in address mark mode
               if (st_q.ctrl1[C1_WAKE] && st_q.status[B_RX_FULL_FLAG])
               begin
                  c2w[C2_MUTE] = st_q.ctrl2[C2_MUTE];
               end
               st_d.ctrl2 = c2w;
            end
         end
         else if (idx == IDX_DIV)
         begin
            st_d.rsp.dat[7:0] = st_q.div;
            if (wr)
            begin
               st_d.div = i_wb.dat[7:0];
            end
         end
      end
      st_d.status = st_q.status & ~clr;

      // Transmit word with optional parity in the MSB
      nb = st_q.ctrl1[C1_M] ? NBITS_9 : NBITS_8;
      tw = {st_q.ctrl1[C1_TX9], st_q.txh};
      if (st_q.ctrl1[C1_PCE])
      begin
         if (st_q.ctrl1[C1_M])
         begin
            tw[8] = (^st_q.txh) ^ st_q.ctrl1[C1_PS];
         end
         else
         begin
            tw[7] = (^st_q.txh[6:0]) ^ st_q.ctrl1[C1_PS];
         end
      end

      // Transmit edge tracking for preamble and break requests
      st_d.te_prev = st_q.ctrl2[C2_TE];
      st_d.sbk_prev = st_q.ctrl2[C2_SBK];
      if (st_q.ctrl2[C2_TE] && !st_q.te_prev && st_q.txs != TX_IDLE)
      begin
         st_d.pre_pend = 1'b1;
      end
      if (!st_q.ctrl2[C2_SBK] && st_q.sbk_prev)
      begin
         st_d.brk_pend = 1'b1;
      end

      // Transmitter
      case (st_q.txs)
         TX_IDLE:
         begin
            st_d.txd = 1'b1;
            st_d.tsmp = 4'h0;
            st_d.tbits = nb + 4'h2;
            if (st_q.ctrl2[C2_TE] && !st_q.te_prev)
            begin
               st_d.txs = TX_WAIT;
            end
            else if (st_q.ctrl2[C2_TE] && !st_q.ctrl1[C1_LPD])
            begin
               if (st_q.brk_pend || st_q.ctrl2[C2_SBK])
               begin
                  st_d.brk_pend = 1'b0;
                  st_d.tsh = 11'h000;
                  st_d.txd = 1'b0;
                  st_d.txs = TX_BRK;
               end
               else if (st_q.pre_pend)
               begin
                  st_d.pre_pend = 1'b0;
                  st_d.tsh = 11'h7FF;
                  st_d.txs = TX_PRE;
               end
               else if (!st_q.status[B_TRANSMIT_EMPTY_FLAG])
               begin
                  // Holding word moves only once software has refilled it
                  st_d.tsh = st_q.ctrl1[C1_M] ? {1'b1, tw, 1'b0} : {2'b11, tw[7:0], 1'b0};
                  st_d.status[B_TRANSMIT_EMPTY_FLAG] = 1'b1;
                  st_d.txd = 1'b0;
                  st_d.txs = TX_DATA;
               end
            end
         end
         TX_WAIT:
         begin
            // One bit time of idle after the transmitter is enabled
            if (tick)
            begin
               st_d.tsmp = st_q.tsmp + 4'h1;
               if (st_q.tsmp == SMP_LAST)
               begin
                  st_d.txs = TX_IDLE;
               end
            end
         end
         default:
         begin
            // Shift a data, preamble or break frame out one bit at a time
            if (tick)
            begin
               st_d.tsmp = st_q.tsmp + 4'h1;
               if (st_q.tsmp == SMP_LAST)
               begin
                  st_d.tsh = {1'b1, st_q.tsh[10:1]};
                  st_d.tbits = st_q.tbits - 4'h1;
                  st_d.txd = st_q.tsh[1];
                  if (st_q.tbits == 4'h1)
                  begin
                     st_d.txd = 1'b1;
                     st_d.txs = TX_IDLE;
                     if (st_q.txs == TX_DATA)
                     begin
                        st_d.status[B_TC] = 1'b1;
                     end
                  end
               end
            end
         end
      endcase

      // Received word, parity check and sample vote
      dat9 = st_q.rm ? st_q.rsh : {1'b0, st_q.rsh[8:1]};
      msb = st_q.rm ? dat9[8] : dat9[7];
      perr = st_q.rpce && (((st_q.rm ? ^dat9 : ^dat9[7:0])) ^ st_q.rps);
      rbit = (st_q.votes[0] & st_q.votes[1]) | (st_q.votes[0] & st_q.votes[2]) |
             (st_q.votes[1] & st_q.votes[2]);
      noisy = (|st_q.votes) && !(&st_q.votes);

      // Receiver
      case (st_q.rxs)
         RX_OFF:
         begin
            st_d.idle_cnt = 8'h00;
            st_d.line_prev = 1'b1;
            if (st_q.ctrl2[C2_RE])
            begin
               st_d.rxs = RX_HUNT;
            end
         end
         RX_HUNT:
         begin
            if (!st_q.ctrl2[C2_RE])
            begin
               st_d.rxs = RX_OFF;
            end
            else if (tick)
            begin
               st_d.line_prev = i_rxd;
               if (st_q.line_prev && !i_rxd)
               begin
                  // Falling edge: start bit, frame settings latched
                  st_d.rxs = RX_BITS;
                  st_d.rsmp = 4'h1;
                  st_d.rbits = 4'h0;
                  st_d.rnoise = 1'b0;
                  st_d.idle_cnt = 8'h00;
                  st_d.rm = st_q.ctrl1[C1_M];
                  st_d.rpce = st_q.ctrl1[C1_PCE];
                  st_d.rps = st_q.ctrl1[C1_PS];
               end
               else if (!i_rxd)
               begin
                  st_d.idle_cnt = 8'h00;
               end
               else if (st_q.idle_cnt != idle_lim)
               begin
                  st_d.idle_cnt = st_q.idle_cnt + 8'h01;
                  if (st_q.idle_cnt == idle_lim - 8'h01)
                  begin
                     // A whole idle frame seen
                     if (st_q.ctrl2[C2_MUTE])
                     begin
                        if (!st_q.ctrl1[C1_WAKE])
                        begin
                           st_d.ctrl2[C2_MUTE] = 1'b0;
                        end
                     end
                     else if (st_q.idle_arm)
                     begin
                        st_d.status[B_IDLE] = 1'b1;
                        st_d.idle_arm = 1'b0;
                     end
                  end
               end
            end
         end
         default:
         begin
            if (!st_q.ctrl2[C2_RE])
            begin
               st_d.rxs = RX_OFF;
            end
            else if (tick)
            begin
               st_d.rsmp = st_q.rsmp + 4'h1;
               if (st_q.rsmp >= SMP_FIRST_VOTE && st_q.rsmp <= SMP_LAST_VOTE)
               begin
                  st_d.votes = {st_q.votes[1:0], i_rxd};
               end
               if (st_q.rsmp == SMP_LAST)
               begin
                  st_d.rnoise = st_q.rnoise | noisy;
                  if (st_q.rbits == 4'h0 && rbit)
                  begin
                     st_d.rxs = RX_HUNT; // False start
                     st_d.line_prev = 1'b1;
                  end
                  else if (st_q.rbits <= (st_q.rm ? NBITS_9 : NBITS_8))
                  begin
                     st_d.rbits = st_q.rbits + 4'h1;
                     if (st_q.rbits != 4'h0)
                     begin
                        st_d.rsh = {rbit, st_q.rsh[8:1]};
                     end
                  end
                  else
                  begin
                     // Stop bit: the frame is complete
                     st_d.rxs = RX_HUNT;
                     st_d.line_prev = i_rxd;
                     deliver = !st_q.ctrl2[C2_MUTE];
                     if (st_q.ctrl2[C2_MUTE] && st_q.ctrl1[C1_WAKE] && msb)
                     begin
                        st_d.ctrl2[C2_MUTE] = 1'b0;
                        deliver = 1'b1;
                     end
                     if (deliver)
                     begin
                        if (st_d.status[B_RX_FULL_FLAG])
                        begin
                           // Held word kept; the new one is dropped
                           st_d.status[B_OR] = 1'b1;
                        end
                        else
                        begin
                           st_d.rxh = dat9[7:0];
                           if (st_q.rm)
                           begin
                              st_d.ctrl1[C1_RX9] = dat9[8];
                           end
                           st_d.status[B_RX_FULL_FLAG] = 1'b1;
                           st_d.status[B_NF] = st_d.status[B_NF] | st_q.rnoise | noisy;
                           st_d.status[B_FE] = st_d.status[B_FE] | !rbit;
                           st_d.status[B_PE] = st_d.status[B_PE] | perr;
                           st_d.idle_arm = 1'b1;
                        end
                     end
                  end
               end
            end
         end
      endcase

      // Shared interrupt level from enabled flags; noise and framing have no enable
      st_d.irq = (st_d.status[B_TRANSMIT_EMPTY_FLAG] & st_d.ctrl2[C2_TIE]) |
                 (st_d.status[B_TC] & st_d.ctrl2[C2_TX_DONE_IRQ_EN]) |
                 ((st_d.status[B_RX_FULL_FLAG] | st_d.status[B_OR]) & st_d.ctrl2[C2_RIE]) |
                 (st_d.status[B_IDLE] & st_d.ctrl2[C2_IDLE_IRQ_EN]) |
                 (st_d.status[B_PE] & st_d.ctrl1[C1_PIE]);
   end

   // State register with synchronous reset
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         st_q <= '0;
         st_q.status <= STATUS_RST;
         st_q.ctrl1 <= CTRL_RST;
         st_q.ctrl2 <= CTRL_RST;
         st_q.div <= DIV_RST;
         st_q.txs <= TX_IDLE;
         st_q.rxs <= RX_OFF;
         st_q.txd <= 1'b1;
         st_q.line_prev <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Outputs straight from the state register
   assign o_wb = st_q.rsp;
   assign o_txd = st_q.txd;
   assign o_irq = st_q.irq;

endmodule

/* File: verif/assc_monitor.sv */
`timescale 1ns/1ns
// Port checker of the serial status and control block
module assc_monitor
   import assc_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Register bus
   input assc_wb_req_t i_wb,
   input assc_wb_rsp_t o_wb,
   // Line and interrupt
   input wire logic i_rxd,
   input wire logic o_txd,
   input wire logic o_irq
);
   logic [6:0] ix; // Register index of the request
   logic req; // Request waiting for its answer
   logic [1:0] en_q, en_d; // Shadow of parity and control two enables
   logic act_q, act_d; // A data or control two write was seen
   assign ix = i_wb.adr[ADR_HI:ADR_LO];
   assign req = i_wb.cyc & i_wb.stb & !o_wb.ack;
   // Next shadow values, taken at the answered write
   always_comb
   begin
      en_d = en_q;
      act_d = act_q | (o_wb.ack & i_wb.we & (ix == IDX_DATA || ix == IDX_CTRL2));
      if (o_wb.ack && i_wb.we && i_wb.sel[0] && ix == IDX_CTRL1)
         en_d[0] = i_wb.dat[C1_PIE];
      if (o_wb.ack && i_wb.we && i_wb.sel[0] && ix == IDX_CTRL2)
         en_d[1] = |i_wb.dat[7:4];
   end
   // Shadow registers, cleared by reset
   always_ff @(posedge i_ref_clk)
   begin
      en_q <= i_rst_n ? en_d : 2'h0;
      act_q <= i_rst_n & act_d;
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   property p_ack_next; req |=> o_wb.ack; endproperty
   a_ack_next: assert property (p_ack_next) else $error("answer not next cycle");
   property p_ack_pulse; o_wb.ack |=> !o_wb.ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than one cycle");
   property p_ack_src; o_wb.ack |-> $past(i_wb.cyc & i_wb.stb); endproperty
   a_ack_src: assert property (p_ack_src) else $error("answer without request");
   property p_dat_hi; o_wb.ack |-> o_wb.dat[31:8] == 24'h0; endproperty
   a_dat_hi: assert property (p_dat_hi) else $error("upper read bits not zero");
   property p_dat_hold; !o_wb.ack |-> $stable(o_wb.dat); endproperty
   a_dat_hold: assert property (p_dat_hold) else $error("read data moved between answers");
   property p_unmap; (req && !i_wb.we && ix == 7'h52) |=> o_wb.dat == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_irq_gate; (en_q == 2'h0) [*3] |-> !o_irq; endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt with all enables off");
   property p_irq_level; $fell(o_irq) |-> o_wb.ack || $past(o_wb.ack) || $past(o_wb.ack, 2); endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt dropped by itself");
   property p_txd_quiet; !act_q |-> o_txd; endproperty
   a_txd_quiet: assert property (p_txd_quiet) else $error("line driven before any transmit write");
endmodule
bind assc_top assc_monitor mon_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_wb(i_wb), .o_wb(o_wb),
   .i_rxd(i_rxd), .o_txd(o_txd), .o_irq(o_irq));

/* File: verif/assc_line_model.sv */
`timescale 1ns/1ns
// Far serial node: sends frames on request and decodes frames it hears
module assc_line_model
(
   // Clock and line
   input wire logic i_clk,
   input wire logic i_txd,
   output logic o_rxd,
   // Frame request
   input wire logic i_go,
   input wire logic i_nine,
   input wire logic i_stop,
   input wire logic [8:0] i_word,
   output logic o_busy,
   // Decoded word
   output logic o_vld,
   output logic [8:0] o_word
);
   localparam int BIT = 16; // Clocks per bit with divider zero
   logic [10:0] fr; // Frame bits, start first
   // Start, data LSB first, chosen stop level, then idle high
   initial
   begin
      o_rxd = 1'b1;
      o_busy = 1'b0;
      forever
      begin
         @(posedge i_clk);
         if (i_go === 1'b1)
         begin
            o_busy <= 1'b1;
            fr = i_nine ? {i_stop, i_word, 1'b0} : {1'b1, i_stop, i_word[7:0], 1'b0}; // Frame bits for the chosen word length
            for (int k = 0; k < 11; k++)
            begin
               o_rxd <= fr[k];
               repeat (BIT) @(posedge i_clk);
            end
            o_rxd <= 1'b1;
            o_busy <= 1'b0;
         end
      end
   end
   // Sample each bit from the block in mid-bit
   initial
   begin
      o_vld = 1'b0;
      o_word = '0;
      forever
      begin
         @(negedge i_txd);
         o_word <= '0;
         repeat (BIT / 2) @(posedge i_clk);
         for (int k = 0; k < (i_nine ? 9 : 8); k++)
         begin
            repeat (BIT) @(posedge i_clk);
            o_word[k] <= i_txd;
         end
         o_vld <= 1'b1;
         @(posedge i_clk);
         o_vld <= 1'b0;
      end
   end
endmodule

/* File: verif/tb_assc_top.sv */
`timescale 1ns/1ns
// Self-checking bench of the serial status and control block
module tb_assc_top;
   import assc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   assc_wb_req_t req = '0;
   assc_wb_rsp_t rsp;
   logic rxd, txd, irq, vld, busy;
   logic go = 1'b0, nine = 1'b0, stop = 1'b1;
   logic [8:0] word = '0, got;
   logic [15:0] rq[$]; // Read notes: mask, value
   logic [8:0] tq[$]; // Words the far node should hear
   logic [15:0] r;
   logic [7:0] b, d;
   int failures = 0, n_checks = 0, seed = 55;
   always #2 clk = ~clk;
   assc_top dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_wb(req), .o_wb(rsp), .i_rxd(rxd), .o_txd(txd), .o_irq(irq));
   assc_line_model far_u (.i_clk(clk), .i_txd(txd), .o_rxd(rxd), .i_go(go), .i_nine(nine), .i_stop(stop),
      .i_word(word), .o_busy(busy), .o_vld(vld), .o_word(got));
   task automatic chk(input string s, input logic [8:0] e, input logic [8:0] g);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %s exp %h got %h", s, e, g);
      end
   endtask
   // Match answers and heard words against the oldest note
   always @(posedge clk)
   begin
      if (rsp.ack === 1'b1 && req.we === 1'b0 && rq.size() > 0)
      begin
         r = rq.pop_front();
         chk("read", {1'b0, r[7:0] & r[15:8]}, {1'b0, rsp.dat[7:0] & r[15:8]});
      end
      if (vld === 1'b1)
         chk("line", tq.pop_front(), got);
   end
   task automatic bus(input logic w, input logic [6:0] ix, input logic [7:0] v);
      int n;
      n = 0;
      @(posedge clk);
      req <= '{1'b1, 1'b1, w, 4'hF, {23'h0, ix, 2'h0}, {24'h0, v}};
      do
         @(posedge clk);
      while (rsp.ack !== 1'b1 && ++n < 40);
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
   endtask
   task automatic rd(input logic [6:0] ix, input logic [7:0] e, input logic [7:0] m);
      rq.push_back({m, e});
      bus(1'b0, ix, 8'h00);
   endtask
   task automatic send(input logic [8:0] w, input logic s);
      int n;
      n = 0;
      @(posedge clk);
      word <= w;
      stop <= s;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      do
         @(posedge clk);
      while (busy !== 1'b0 && ++n < 400);
      repeat (16) @(posedge clk);
   endtask
   task automatic xmit(input logic [8:0] w);
      tq.push_back(w);
      rd(IDX_STATUS, 8'h80, 8'h80); // Holding empty before load
      bus(1'b1, IDX_DATA, w[7:0]);
      for (int n = 0; n < 400 && tq.size() > 0; n++)
         @(posedge clk);
      repeat (32) @(posedge clk);
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog against a hung run
   initial
   begin
      #100000;
      failures++;
      finish_test();
   end
   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd(IDX_STATUS, STATUS_RST, 8'hFF); // Status after reset
      rd(IDX_CTRL2, CTRL_RST, 8'hFF);
      rd(7'h52, 8'h00, 8'hFF);
      bus(1'b1, IDX_DIV, 8'h00);
      bus(1'b1, IDX_CTRL2, 8'h2C);
      repeat (20) @(posedge clk);
      d = $random(seed);
      xmit({1'b0, d}); // Sent word
      rd(IDX_STATUS, 8'hC0, 8'hC0); // Done flags
      d = $random(seed);
      send({1'b0, d}, 1'b1);
      chk("irq", 9'h001, {8'h0, irq}); // Full raises irq
      rd(IDX_STATUS, 8'h20, 8'h24); // Full, no noise
      rd(IDX_DATA, d, 8'hFF); // Word
      repeat (4) @(posedge clk);
      chk("irq", 9'h000, {8'h0, irq}); // Level drops
      repeat (200) @(posedge clk);
      rd(IDX_STATUS, 8'h10, 8'h10); // Idle seen
      rd(IDX_DATA, 8'h00, 8'h00);
      repeat (200) @(posedge clk);
      rd(IDX_STATUS, 8'h00, 8'h10); // Idle not rearmed
      b = $random(seed);
      d = $random(seed);
      send({1'b0, b}, 1'b1);
      send({1'b0, d}, 1'b0);
      rd(IDX_STATUS, 8'h28, 8'h2A); // Overrun wins over framing
      rd(IDX_DATA, b, 8'hFF); // Held word kept
      send({1'b0, b}, 1'b0);
      rd(IDX_STATUS, 8'h22, 8'h22); // Framing
      rd(IDX_DATA, b, 8'hFF);
      bus(1'b1, IDX_CTRL2, 8'h0C);
      for (int k = 0; k < 4; k++)
      begin
         d = $random(seed);
         bus(1'b1, IDX_CTRL1, {5'h0, 1'b1, k[1], 1'b1});
         send({1'b0, ^d[6:0] ^ k[1] ^ k[0], d[6:0]}, 1'b1);
         chk("irq", {8'h0, k[0]}, {8'h0, irq}); // Parity irq
         rd(IDX_STATUS, {7'h0, k[0]}, 8'h01); // Parity sense
         rd(IDX_DATA, 8'h00, 8'h00);
      end
      bus(1'b1, IDX_CTRL1, 8'h50);
      nine <= 1'b1;
      d = $random(seed);
      send({1'b1, d}, 1'b1);
      rd(IDX_CTRL1, 8'hD0, 8'hFF); // Ninth bit
      rd(IDX_DATA, d, 8'hFF);
      xmit({1'b1, d}); // Ninth bit out
      rd(IDX_STATUS, 8'h30, 8'h30); // Held word and idle pending
      rd(IDX_DATA, d, 8'hFF);
      bus(1'b1, IDX_CTRL2, 8'h0E); // Mute only after a byte came
      d = $random(seed);
      send({1'b0, d}, 1'b1);
      repeat (200) @(posedge clk);
      rd(IDX_CTRL2, 8'h0C, 8'hFF); // Idle frame wakes the receiver
      rd(IDX_STATUS, 8'h00, 8'h30); // Muted word dropped, no idle flag
      finish_test();
   end
endmodule
